/* hw/crz_remap.sv */
// Custom register zone remapper: pointer lists, alias window and auto-save
// How it works
// RQ1 - Registers 1200..1399 hold pointers naming objects of the standard register table.
// RQ2 - Pointers 1200..1299 define the read-only custom zone.
// RQ3 - Pointers 1300..1399 define the read/write custom zone.
// RQ4 - Reading 2000+n returns the object named by pointer 1200+n.
// RQ5 - Reading or writing 2100+n acts on the object named by pointer 1300+n.
// RQ6 - After a configuration download the pointers are saved without any command.
// RQ7 - Writes to 2000..2099 are rejected and change no object.
module crz_remap (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        reqValid,
	input  wire logic        reqWrite,
	input  wire logic [15:0] reqAddr,
	input  wire logic [15:0] reqWData,
	output logic             reqReady,
	output logic             respValid,
	output logic [15:0]      respData,
	output logic             respError,
	output logic             objReq,
	output logic             objWrite,
	output logic [15:0]      objAddr,
	output logic [15:0]      objWData,
	input  wire logic [15:0] objRData,
	input  wire logic        objAck,
	input  wire logic        downloadDone,
	output logic             saveBusy,
	output logic             nvWrite,
	output logic [7:0]       nvIndex,
	output logic [15:0]      nvData,
	input  wire logic        nvAck
);
	crz_save_if sv ();

	crz_pkg::crz_bus_st_t st_q, st_d;
	crz_pkg::crz_region_t reqRegion;
	logic        reqReady_q, reqReady_d;
	logic        respValid_q, respValid_d;
	logic        respError_q, respError_d;
	logic [15:0] respData_q, respData_d;
	logic        objReq_q, objReq_d;
	logic        objWrite_q, objWrite_d;
	logic [15:0] objAddr_q, objAddr_d;
	logic [15:0] objWData_q, objWData_d;
	logic        saveStart_q, saveStart_d;
	logic [15:0] ptrQ [crz_pkg::PTR_COUNT];
	logic [15:0] ptrD [crz_pkg::PTR_COUNT];
	logic [7:0]  ptrIdx;
	logic [7:0]  aliasIdx;
	logic        ptrWe;
	logic        accept;

	// Both lists and both alias halves are contiguous, so one offset serves each
	assign reqRegion = crz_pkg::region_of(reqAddr);
	assign ptrIdx    = 8'(reqAddr - crz_pkg::PTR_RO_LO);
	assign aliasIdx  = 8'(reqAddr - crz_pkg::ALIAS_RO_LO);
	assign accept    = reqValid && reqReady_q;

	// Pointer storage next values, one entry per loop pass
	genvar gi;
	generate
		for (gi = 0; gi < crz_pkg::PTR_COUNT; gi++)
		begin : g_ptr
			// RQ1 pointer entry update
			assign ptrD[gi] = (ptrWe && ptrIdx == 8'(gi)) ? reqWData : ptrQ[gi];
		end
	endgenerate

	// Request routing and response sequencing
	always_comb
	begin
		st_d        = st_q;
		respValid_d = 1'b0;
		respError_d = 1'b0;
		respData_d  = respData_q;
		objReq_d    = objReq_q;
		objWrite_d  = objWrite_q;
		objAddr_d   = objAddr_q;
		objWData_d  = objWData_q;
		ptrWe       = 1'b0;
		// RQ6 save kicked by download
		saveStart_d = downloadDone;
		case (st_q)
			crz_pkg::ST_IDLE:
			begin
				if (accept)
				begin
					case (reqRegion)
						crz_pkg::REG_PTR:
						begin
							// RQ1 pointer list access
							respValid_d = 1'b1;
							respData_d  = reqWrite ? reqWData : ptrQ[ptrIdx];
							// Refused mid-save so stored copy stays coherent
							respError_d = reqWrite && sv.busy;
							ptrWe       = reqWrite && !sv.busy;
						end
						crz_pkg::REG_ALIAS_RO:
						begin
							if (reqWrite)
							begin
								// RQ7 read-only alias write refused
								respValid_d = 1'b1;
								respError_d = 1'b1;
								respData_d  = reqWData;
							end
							else
							begin
								// RQ2 RQ4 read through read-only pointer
								objReq_d   = 1'b1;
								objWrite_d = 1'b0;
								objAddr_d  = ptrQ[aliasIdx];
								st_d       = crz_pkg::ST_WAIT;
							end
						end
						crz_pkg::REG_ALIAS_RW:
						begin
							// RQ3 RQ5 access through read/write pointer
							objReq_d   = 1'b1;
							objWrite_d = reqWrite;
							objAddr_d  = ptrQ[aliasIdx];
							objWData_d = reqWData;
							st_d       = crz_pkg::ST_WAIT;
						end
						default:
						begin
							// Standard table passes straight through
							objReq_d   = 1'b1;
							objWrite_d = reqWrite;
							objAddr_d  = reqAddr;
							objWData_d = reqWData;
							st_d       = crz_pkg::ST_WAIT;
						end
					endcase
				end
			end
			crz_pkg::ST_WAIT:
			begin
				if (objAck)
				begin
					// RQ4 answer carries object data
					objReq_d    = 1'b0;
					respValid_d = 1'b1;
					respData_d  = objWrite_q ? objWData_q : objRData;
					st_d        = crz_pkg::ST_IDLE;
				end
			end
			default: st_d = crz_pkg::ST_IDLE;
		endcase
		reqReady_d = (st_d == crz_pkg::ST_IDLE);
	end

	// Registers only; pointers clear at reset until software reloads them
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			st_q        <= crz_pkg::ST_IDLE;
			reqReady_q  <= 1'b0;
			respValid_q <= 1'b0;
			respError_q <= 1'b0;
			respData_q  <= crz_pkg::DATA_ZERO;
			objReq_q    <= 1'b0;
			objWrite_q  <= 1'b0;
			objAddr_q   <= crz_pkg::DATA_ZERO;
			objWData_q  <= crz_pkg::DATA_ZERO;
			saveStart_q <= 1'b0;
			for (int i = 0; i < crz_pkg::PTR_COUNT; i++)
				ptrQ[i] <= crz_pkg::PTR_RESET;
		end
		else
		begin
			st_q        <= st_d;
			reqReady_q  <= reqReady_d;
			respValid_q <= respValid_d;
			respError_q <= respError_d;
			respData_q  <= respData_d;
			objReq_q    <= objReq_d;
			objWrite_q  <= objWrite_d;
			objAddr_q   <= objAddr_d;
			objWData_q  <= objWData_d;
			saveStart_q <= saveStart_d;
			ptrQ        <= ptrD;
		end
	end

	// Save engine reads the entry it is pointing at
	assign sv.start = saveStart_q;
	assign sv.entry = ptrQ[sv.idx];

	crz_nv_saver u_saver (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.sv      (sv),
		.nvWrite (nvWrite),
		.nvIndex (nvIndex),
		.nvData  (nvData),
		.nvAck   (nvAck)
	);

	assign reqReady  = reqReady_q;
	assign respValid = respValid_q;
	assign respData  = respData_q;
	assign respError = respError_q;
	assign objReq    = objReq_q;
	assign objWrite  = objWrite_q;
	assign objAddr   = objAddr_q;
	assign objWData  = objWData_q;
	assign saveBusy  = sv.busy;

	property p_ptr_store;
		@(posedge ref_clk) disable iff (!reset_n)
		(accept && reqWrite && crz_pkg::region_of(reqAddr) == crz_pkg::REG_PTR && !sv.busy)
		|=> (ptrQ[$past(ptrIdx)] == $past(reqWData) && respValid && !respError);
	endproperty
	a_ptr_store: assert property (p_ptr_store) else $error("pointer write lost"); // RQ1

	property p_ro_read;
		@(posedge ref_clk) disable iff (!reset_n)
		(accept && !reqWrite && crz_pkg::region_of(reqAddr) == crz_pkg::REG_ALIAS_RO)
		|=> (objReq && !objWrite && objAddr == ptrQ[$past(aliasIdx)]);
	endproperty
	a_ro_read: assert property (p_ro_read) else $error("read-only alias misrouted"); // RQ2

	property p_rw_write;
		@(posedge ref_clk) disable iff (!reset_n)
		(accept && reqWrite && crz_pkg::region_of(reqAddr) == crz_pkg::REG_ALIAS_RW)
		|=> (objReq && objWrite && objWData == $past(reqWData));
	endproperty
	a_rw_write: assert property (p_rw_write) else $error("read/write alias write lost"); // RQ3

	property p_read_answer;
		@(posedge ref_clk) disable iff (!reset_n)
		(objReq && objAck && !objWrite) |=> (respValid && !respError && respData == $past(objRData));
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("object data not returned"); // RQ4

	property p_rw_route;
		@(posedge ref_clk) disable iff (!reset_n)
		(accept && crz_pkg::region_of(reqAddr) == crz_pkg::REG_ALIAS_RW)
		|=> (objReq && objAddr == ptrQ[$past(aliasIdx)]);
	endproperty
	a_rw_route: assert property (p_rw_route) else $error("read/write alias misrouted"); // RQ5

	property p_auto_save;
		@(posedge ref_clk) disable iff (!reset_n)
		downloadDone |-> ##2 saveBusy;
	endproperty
	a_auto_save: assert property (p_auto_save) else $error("download not saved"); // RQ6

	property p_ro_reject;
		@(posedge ref_clk) disable iff (!reset_n)
		(accept && reqWrite && crz_pkg::region_of(reqAddr) == crz_pkg::REG_ALIAS_RO)
		|=> (respValid && respError && !objReq) ##1 !objReq;
	endproperty
	a_ro_reject: assert property (p_ro_reject) else $error("read-only alias write accepted"); // RQ7

	property p_req_hold;
		@(posedge ref_clk) disable iff (!reset_n)
		(objReq && !objAck) |=> (objReq && $stable(objAddr) && !reqReady);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("object request dropped"); // RQ5

	cover_ro_read: cover property (@(posedge ref_clk) disable iff (!reset_n)
		accept && !reqWrite && reqRegion == crz_pkg::REG_ALIAS_RO);
	cover_rw_write: cover property (@(posedge ref_clk) disable iff (!reset_n)
		accept && reqWrite && reqRegion == crz_pkg::REG_ALIAS_RW);
	cover_reject: cover property (@(posedge ref_clk) disable iff (!reset_n)
		respValid && respError);
	cover_download: cover property (@(posedge ref_clk) disable iff (!reset_n)
		downloadDone ##1 1'b1 ##1 saveBusy);
endmodule : crz_remap

/* hw/crz_pkg.sv */
// Shared constants, types and decode for the custom register zone remapper
package crz_pkg;
	localparam int unsigned ADDR_W     = 16;
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned IDX_W      = 8;
	localparam int unsigned PTR_COUNT  = 200;
	// Pointer list: read-only half then read/write half
	localparam logic [15:0] PTR_RO_LO   = 16'h04B0;
	localparam logic [15:0] PTR_RO_HI   = 16'h0513;
	localparam logic [15:0] PTR_RW_LO   = 16'h0514;
	localparam logic [15:0] PTR_RW_HI   = 16'h0577;
	// Alias window: read-only half then read/write half
	localparam logic [15:0] ALIAS_RO_LO = 16'h07D0;
	localparam logic [15:0] ALIAS_RO_HI = 16'h0833;
	localparam logic [15:0] ALIAS_RW_LO = 16'h0834;
	localparam logic [15:0] ALIAS_RW_HI = 16'h0897;
	localparam logic [7:0]  LAST_IDX    = 8'hC7;
	localparam logic [7:0]  FIRST_IDX   = 8'h00;
	localparam logic [7:0]  IDX_STEP    = 8'h01;
	localparam logic [15:0] PTR_RESET   = 16'h0000;
	localparam logic [15:0] DATA_ZERO   = 16'h0000;

	typedef enum logic [1:0] {REG_PTR, REG_ALIAS_RO, REG_ALIAS_RW, REG_DIRECT} crz_region_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_WAIT = 2'b10} crz_bus_st_t;
	typedef enum logic [2:0] {SV_IDLE = 3'b001, SV_LOAD = 3'b010, SV_WRITE = 3'b100} crz_save_st_t;

	// Classify a register number into the zone it falls in
	function automatic crz_region_t region_of(input logic [15:0] a);
		if (a >= PTR_RO_LO && a <= PTR_RW_HI)
			return REG_PTR;
		else if (a >= ALIAS_RO_LO && a <= ALIAS_RO_HI)
			return REG_ALIAS_RO;
		else if (a >= ALIAS_RW_LO && a <= ALIAS_RW_HI)
			return REG_ALIAS_RW;
		else
			return REG_DIRECT;
	endfunction : region_of
endpackage : crz_pkg

/* hw/crz_save_if.sv */
// Link between the remapper and its automatic pointer save engine
interface crz_save_if;
	logic        start;
	logic        busy;
	logic [7:0]  idx;
	logic [15:0] entry;

	modport ctl (output start, output entry, input busy, input idx);
	modport eng (input start, input entry, output busy, output idx);
endinterface : crz_save_if

/* hw/crz_nv_saver.sv */
// Engine that copies every pointer entry to non-volatile storage
module crz_nv_saver (
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	crz_save_if.eng          sv,
	output logic             nvWrite,
	output logic [7:0]       nvIndex,
	output logic [15:0]      nvData,
	input  wire logic        nvAck
);
	crz_pkg::crz_save_st_t st_q, st_d;
	logic [7:0]  idx_q, idx_d;
	logic [15:0] data_q, data_d;
	logic        wr_q, wr_d;
	logic        busy_q, busy_d;
	logic        pend_q, pend_d;

	// Next-state: walk all entries; a download landing mid-save restarts the walk after it
	always_comb
	begin
		st_d   = st_q;
		idx_d  = idx_q;
		data_d = data_q;
		wr_d   = wr_q;
		busy_d = busy_q;
		pend_d = pend_q | (sv.start && st_q != crz_pkg::SV_IDLE);
		case (st_q)
			crz_pkg::SV_IDLE:
			begin
				if (sv.start)
				begin
					st_d   = crz_pkg::SV_LOAD;
					idx_d  = crz_pkg::FIRST_IDX;
					busy_d = 1'b1;
				end
			end
			crz_pkg::SV_LOAD:
			begin
				data_d = sv.entry;
				wr_d   = 1'b1;
				st_d   = crz_pkg::SV_WRITE;
			end
			crz_pkg::SV_WRITE:
			begin
				if (nvAck)
				begin
					wr_d = 1'b0;
					if (pend_d)
					begin
						// Newer configuration arrived: save it from the top
						pend_d = 1'b0;
						idx_d  = crz_pkg::FIRST_IDX;
						st_d   = crz_pkg::SV_LOAD;
					end
					else if (idx_q == crz_pkg::LAST_IDX)
					begin
						busy_d = 1'b0;
						st_d   = crz_pkg::SV_IDLE;
					end
					else
					begin
						idx_d = idx_q + crz_pkg::IDX_STEP;
						st_d  = crz_pkg::SV_LOAD;
					end
				end
			end
			default: st_d = crz_pkg::SV_IDLE;
		endcase
	end

	// Registers only
	always_ff @(posedge ref_clk)
	begin
		if (!reset_n)
		begin
			st_q   <= crz_pkg::SV_IDLE;
			idx_q  <= crz_pkg::FIRST_IDX;
			data_q <= crz_pkg::DATA_ZERO;
			wr_q   <= 1'b0;
			busy_q <= 1'b0;
			pend_q <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			idx_q  <= idx_d;
			data_q <= data_d;
			wr_q   <= wr_d;
			busy_q <= busy_d;
			pend_q <= pend_d;
		end
	end

	assign sv.busy = busy_q;
	assign sv.idx  = idx_q;
	assign nvWrite = wr_q;
	assign nvIndex = idx_q;
	assign nvData  = data_q;

	// RQ6 save follows start
	property p_save_starts;
		@(posedge ref_clk) disable iff (!reset_n)
		(sv.start && st_q == crz_pkg::SV_IDLE) |-> ##2 (nvWrite && nvIndex == crz_pkg::FIRST_IDX);
	endproperty
	a_save_starts: assert property (p_save_starts) else $error("save did not begin"); // RQ6

	cover_save_done: cover property (@(posedge ref_clk) disable iff (!reset_n)
		$fell(busy_q));
endmodule : crz_nv_saver

/* bench/crz_obj_model.sv */
// Behavioural standard register table and non-volatile store facing the remapper
module crz_obj_model (
	input  wire logic        ref_clk,
	input  wire logic        objReq,
	input  wire logic        objWrite,
	input  wire logic [15:0] objAddr,
	input  wire logic [15:0] objWData,
	output logic [15:0]      objRData,
	output logic             objAck,
	input  wire logic [1:0]  ackDelay,
	input  wire logic        nvWrite,
	input  wire logic [7:0]  nvIndex,
	input  wire logic [15:0] nvData,
	output logic             nvAck
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:255];
	logic [15:0] nvMem [0:199];
	logic [1:0]  waitCnt = 2'h0;

	initial
	begin
		objRData = 16'h0000;
		objAck = 1'b0;
		nvAck = 1'b0;
		for (int i = 0; i < 256; i++)
			mem[i] = 16'hA500 | 16'(i);
	end

	// Table answers after a chosen delay; read data is junk outside the ack cycle
	always @(posedge ref_clk)
	begin
		objAck <= 1'b0;
		objRData <= ~objRData;
		nvAck <= nvWrite && !nvAck;
		if (objReq && !objAck)
		begin
			if (waitCnt == ackDelay)
			begin
				objAck <= 1'b1;
				waitCnt <= 2'h0;
				objRData <= mem[objAddr[7:0]];
				if (objWrite)
					mem[objAddr[7:0]] <= objWData;
			end
			else
				waitCnt <= waitCnt + 2'h1;
		end
		// Store keeps every entry it accepts so the bench can inspect it
		if (nvWrite && !nvAck)
			nvMem[nvIndex] <= nvData;
	end
endmodule : crz_obj_model

/* bench/tb_top.sv */
// Self-checking bench for the custom register zone remapper
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] PA [6] = '{16'h04B0, 16'h04B3, 16'h0513, 16'h0514, 16'h0517,
		16'h0577};
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        reqValid = 1'b0;
	logic        reqWrite = 1'b0;
	logic [15:0] reqAddr = 16'h0000;
	logic [15:0] reqWData = 16'h0000;
	logic        downloadDone = 1'b0;
	logic [1:0]  ackDelay = 2'h0;
	logic        reqReady, respValid, respError, objReq, objWrite, objAck;
	logic        saveBusy, nvWrite, nvAck;
	logic [15:0] respData, objAddr, objWData, objRData, nvData;
	logic [7:0]  nvIndex;
	logic [17:0] expQ [$];
	logic [17:0] e;
	logic [15:0] pv [6];
	logic [15:0] dA, dB, dC;
	int          err_total = 0;
	int          n_checks = 0;
	int          seed = 32'h0bd7_7395;
	int          n;

	crz_remap i_crz_remap (.ref_clk(ref_clk), .reset_n(reset_n), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqAddr(reqAddr), .reqWData(reqWData), .reqReady(reqReady),
		.respValid(respValid), .respData(respData), .respError(respError), .objReq(objReq),
		.objWrite(objWrite), .objAddr(objAddr), .objWData(objWData), .objRData(objRData),
		.objAck(objAck), .downloadDone(downloadDone), .saveBusy(saveBusy),
		.nvWrite(nvWrite), .nvIndex(nvIndex), .nvData(nvData), .nvAck(nvAck));
	crz_obj_model i_crz_obj_model (.ref_clk(ref_clk), .objReq(objReq), .objWrite(objWrite),
		.objAddr(objAddr), .objWData(objWData), .objRData(objRData), .objAck(objAck),
		.ackDelay(ackDelay), .nvWrite(nvWrite), .nvIndex(nvIndex), .nvData(nvData),
		.nvAck(nvAck));

	// 40 MHz clock
	always #12.5 ref_clk = ~ref_clk;

	task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	// Request held from a falling edge until the rising edge that sees reqReady
	task automatic req(input logic w, input logic [15:0] a, input logic [15:0] d,
		input logic [17:0] x);
		int k;
		expQ.push_back(x);
		@(negedge ref_clk);
		ackDelay = 2'($random(seed));
		reqValid = 1'b1;
		reqWrite = w;
		reqAddr = a;
		reqWData = d;
		k = 0;
		while (reqReady !== 1'b1 && k < 100)
		begin
			@(negedge ref_clk);
			k++;
		end
		@(negedge ref_clk);
		reqValid = 1'b0;
		k = 0;
		while (expQ.size() != 0 && k < 100)
		begin
			@(negedge ref_clk);
			k++;
		end
		if (expQ.size() != 0)
			chk("answer", 17'h0_0000, 17'h1_FFFF);
	endtask : req

	// Expectation word: care about data, refused flag, data
	task automatic rd(input logic [15:0] a, input logic [15:0] d);
		req(1'b0, a, 16'h0000, {2'b10, d});
	endtask : rd

	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		req(1'b1, a, d, {2'b10, d});
	endtask : wr

	task automatic rf(input logic [15:0] a, input logic [15:0] d);
		req(1'b1, a, d, {2'b01, 16'h0000});
	endtask : rf

	// Watcher: each answer pulse is matched with the oldest expectation
	always @(negedge ref_clk)
		if (respValid === 1'b1)
		begin
			if (expQ.size() == 0)
				chk("unexpected answer", 17'h0_0001, 17'h0_0000);
			else
			begin
				e = expQ.pop_front();
				if (e[17])
					chk("respData", {respError, respData}, e[16:0]);
				else
					chk("respError", {respError, 16'h0000}, {e[16], 16'h0000});
			end
		end

	// Watchdog sized well beyond the whole sequence
	initial
	begin
		#500000;
		err_total++;
		finish_test();
	end

	initial
	begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		reset_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk("idle outputs", {respValid, objReq, saveBusy, nvWrite, reqReady}, 17'h1);
		rd(16'h04E2, 16'h0000);
		$display("test reset done");
		dA = 16'($random(seed));
		dB = 16'($random(seed));
		dC = ~dB;
		for (int i = 0; i < 6; i++)
			pv[i] = 16'($random(seed));
		// Objects kept apart in the table so one alias cannot hide another
		pv[1] = {10'h004, pv[1][5:0]};
		pv[4] = {10'h005, pv[4][5:0]};
		for (int i = 0; i < 6; i++)
			wr(PA[i], pv[i]);
		for (int i = 0; i < 6; i++)
			rd(PA[i], pv[i]);
		$display("test pointers done");
		wr(pv[1], dA);
		wr(pv[4], dB);
		rd(16'h07D3, dA);
		rd(16'h0837, dB);
		wr(16'h0837, dC);
		rd(pv[4], dC);
		rf(16'h07D3, ~dA);
		rd(pv[1], dA);
		rd(16'h07D3, dA);
		$display("test alias done");
		@(negedge ref_clk);
		downloadDone = 1'b1;
		@(negedge ref_clk);
		downloadDone = 1'b0;
		n = 0;
		while (saveBusy !== 1'b1 && n < 10)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("saveBusy", {16'h0000, saveBusy}, 17'h1);
		rf(16'h04B3, 16'h1234);
		// A second download mid-save restarts the walk from the first entry
		@(negedge ref_clk);
		downloadDone = 1'b1;
		@(negedge ref_clk);
		downloadDone = 1'b0;
		n = 0;
		while (!(nvWrite === 1'b1 && nvIndex === 8'h00) && n < 16)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("restart index", {8'h00, nvWrite, nvIndex}, 17'h0_0100);
		n = 0;
		while (saveBusy !== 1'b0 && n < 2000)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("saveBusy", {16'h0000, saveBusy}, 17'h0);
		for (int i = 0; i < 6; i++)
			chk("stored entry", {1'b0, i_crz_obj_model.nvMem[PA[i] - 16'h04B0]},
				{1'b0, pv[i]});
		rd(16'h04B3, pv[1]);
		$display("test save done");
		finish_test();
	end
endmodule : tb_top
